// ### tbr_pkg.sv
// Shared constants and CRC function for the Type B request/answer exchange
package tbr_pkg;
  localparam logic [7:0]  TBR_CMD_REQ      = 8'h05;
  localparam logic [7:0]  TBR_RSP_ATQB     = 8'h50;
  localparam logic [7:0]  TBR_PROTO_RATE   = 8'h91;
  localparam logic [7:0]  TBR_PROTO_FRAME  = 8'h81;
  localparam logic [3:0]  TBR_PROTO3_LOW   = 4'h0;
  localparam logic [31:0] TBR_APP_DATA     = 32'h0000_0000;
  localparam logic [7:0]  TBR_AFI_ALL      = 8'h00;
  localparam logic [3:0]  TBR_NIBBLE_ANY   = 4'h0;
  localparam int          TBR_WAKE_BIT     = 3;
  localparam logic [2:0]  TBR_REQ_LEN      = 3'h5;
  localparam logic [3:0]  TBR_RSP_LEN      = 4'he;
  localparam logic [3:0]  TBR_RSP_CRC_POS  = 4'hc;
  localparam logic [15:0] TBR_CRC_INIT     = 16'hffff;
  localparam logic [15:0] TBR_CRC_POLY     = 16'h8408;
  // Turnaround guard after an answer
  localparam int TBR_CLK_NS      = 40;
  localparam int TBR_ETU_NS      = 9440;
  localparam int TBR_GUARD_ETU   = 10;
  localparam int TBR_GUARD_FS    = 32;
  localparam int TBR_SUBCARR_KHZ = 848;
  localparam int TBR_GUARD_NS    = TBR_GUARD_ETU * TBR_ETU_NS
                                 + (TBR_GUARD_FS * 1000000 + TBR_SUBCARR_KHZ - 1) / TBR_SUBCARR_KHZ;
  localparam int TBR_GUARD_CYC   = (TBR_GUARD_NS + TBR_CLK_NS - 1) / TBR_CLK_NS;

  function automatic logic [15:0] tbr_crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ TBR_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : tbr_crc_step
endpackage : tbr_pkg

// ### tbr_link_if.sv
// Byte-stream link between reader and tag
`timescale 1ns/1ps
interface tbr_link_if;
  logic [7:0] rq_data;
  logic       rq_valid;
  logic       rq_last;
  logic       rq_ready;
  logic [7:0] rs_data;
  logic       rs_valid;
  logic       rs_last;
  logic       rs_ready;
  modport tag (input rq_data, rq_valid, rq_last, rs_ready,
               output rq_ready, rs_data, rs_valid, rs_last);
  modport reader (output rq_data, rq_valid, rq_last, rs_ready,
                  input rq_ready, rs_data, rs_valid, rs_last);
endinterface : tbr_link_if

// ### tbr_tag.sv
// Tag end: request checking, answer building and answer FIFO
// Summary of operation
// R1: Request code 05, family, parameter, two-byte CRC
// R2: Request form answered while idle
// R3: Wake-up form answered in halt and idle
// R4: Family byte zero selects every tag
// R5: Y0 matches upper nibble, 0Y lower nibble
// R6: Other nonzero family must equal system code
// R7: Parameter bits 7 to 5 ignored
// R8: Slot field ignored, always answer at once
// R9: Answer: 50, identifier, data, protocol, CRC
// R10: Application data bytes are all zero
// R11: First protocol byte is 91
// R12: Second protocol byte is 81
// R13: Reader waits 10 etu plus 32/fs after answer
// R14: Third protocol byte carries wait integer high
// R15: Application coding bits read 00
// R16: Frame option bits read 00
// R17: Bad CRC or wrong length gets no answer
// R18: Halted tag ignores request, wakes on wake-up
`timescale 1ns/1ps
module tbr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("tbr_fifo: DEPTH must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty     = (wr_r == rd_r);
  assign in_ready  = ce && !full;
  assign out_valid = ce && !empty;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

  // Registered storage drives the data output directly
  assign out_data = mem_r[rd_r[AW-1:0]];
endmodule : tbr_fifo

module tbr_tag
  import tbr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  tbr_link_if.tag          link,
  input  wire logic [7:0]  family_code,
  input  wire logic [31:0] pupi,
  input  wire logic [3:0]  fwi,
  input  wire logic        halt_req,
  output logic             halted,
  output logic             answered
);
  if (FIFO_DEPTH < 16) begin : g_chk
    $error("tbr_tag: FIFO_DEPTH must hold a whole answer");
  end

  typedef enum logic [1:0] {
    TBR_T_RX   = 2'b00,
    TBR_T_EVAL = 2'b01,
    TBR_T_TX   = 2'b10
  } tbr_tstate_type;

  tbr_tstate_type state_r;
  logic [7:0]  buf_r [TBR_REQ_LEN];
  logic [2:0]  cnt_r;
  logic        over_r;
  logic [15:0] rx_crc_r;
  logic [3:0]  tx_idx_r;
  logic [15:0] tx_crc_r;
  logic        halted_r;
  logic        answered_r;
  logic        rx_take;
  logic        accept;
  logic        sel;
  logic [7:0]  tx_byte;
  logic        f_ready;
  logic        f_push;
  logic [8:0]  f_out;

  assign link.rq_ready = ce && (state_r == TBR_T_RX);
  assign rx_take       = link.rq_valid && link.rq_ready;

  // Family selection: zero selects all, nibble forms, else exact code
  always_comb begin
    logic [7:0] afi;
    afi = buf_r[1];
    if (afi == TBR_AFI_ALL) begin
      sel = 1'b1; // R4
    end else if (afi[3:0] == TBR_NIBBLE_ANY) begin
      sel = (afi[7:4] == family_code[7:4]); // R5
    end else if (afi[7:4] == TBR_NIBBLE_ANY) begin
      sel = (afi[3:0] == family_code[3:0]); // R5
    end else begin
      sel = (afi == family_code); // R6
    end
  end

  // Slot and upper parameter bits are never looked at
  always_comb begin
    accept = !over_r && (cnt_r == TBR_REQ_LEN) // R17
          && (~rx_crc_r == {buf_r[4], buf_r[3]}) // R17
          && (buf_r[0] == TBR_CMD_REQ) // R1
          && sel // R7 R8
          && (buf_r[2][TBR_WAKE_BIT] || !halted_r); // R2 R3 R18
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= TBR_T_RX;
    end else if (ce) begin
      case (state_r)
        TBR_T_RX: begin
          if (rx_take && link.rq_last) begin
            state_r <= TBR_T_EVAL;
          end
        end
        TBR_T_EVAL: begin
          state_r <= accept ? TBR_T_TX : TBR_T_RX; // R8 R17
        end
        TBR_T_TX: begin
          if (f_push && tx_idx_r == TBR_RSP_LEN - 4'h1) begin
            state_r <= TBR_T_RX;
          end
        end
        default: state_r <= TBR_T_RX;
      endcase
    end
  end

  // Receive side: count, keep first five bytes, CRC over first three
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r    <= '0;
      over_r   <= 1'b0;
      rx_crc_r <= TBR_CRC_INIT;
      for (int i = 0; i < TBR_REQ_LEN; i++) begin
        buf_r[i] <= '0;
      end
    end else if (ce) begin
      if (state_r == TBR_T_EVAL) begin
        cnt_r    <= '0;
        over_r   <= 1'b0;
        rx_crc_r <= TBR_CRC_INIT;
      end else if (rx_take) begin
        if (cnt_r == TBR_REQ_LEN) begin
          over_r <= 1'b1; // R17
        end else begin
          buf_r[cnt_r] <= link.rq_data;
          cnt_r        <= cnt_r + 3'h1;
        end
        if (cnt_r < TBR_REQ_LEN - 3'h2) begin
          rx_crc_r <= tbr_crc_step(rx_crc_r, link.rq_data); // R17
        end
      end
    end
  end

  // Halt follows the outside command decoder; a set beats a wake-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halted_r <= 1'b0;
    end else if (ce) begin
      if (halt_req) begin
        halted_r <= 1'b1;
      end else if (state_r == TBR_T_EVAL && accept) begin
        halted_r <= 1'b0; // R18
      end
    end
  end

  always_comb begin
    case (tx_idx_r)
      4'h0:    tx_byte = TBR_RSP_ATQB; // R9
      4'h1:    tx_byte = pupi[31:24];
      4'h2:    tx_byte = pupi[23:16];
      4'h3:    tx_byte = pupi[15:8];
      4'h4:    tx_byte = pupi[7:0];
      4'h5:    tx_byte = TBR_APP_DATA[31:24]; // R10
      4'h6:    tx_byte = TBR_APP_DATA[23:16]; // R10
      4'h7:    tx_byte = TBR_APP_DATA[15:8]; // R10
      4'h8:    tx_byte = TBR_APP_DATA[7:0]; // R10
      4'h9:    tx_byte = TBR_PROTO_RATE; // R11
      4'ha:    tx_byte = TBR_PROTO_FRAME; // R12
      4'hb:    tx_byte = {fwi, TBR_PROTO3_LOW}; // R14 R15 R16
      4'hc:    tx_byte = ~tx_crc_r[7:0]; // R9
      default: tx_byte = ~tx_crc_r[15:8]; // R9
    endcase
  end

  // Answer is pushed whole; a full FIFO simply stalls the builder
  assign f_push = (state_r == TBR_T_TX) && f_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_idx_r   <= '0;
      tx_crc_r   <= TBR_CRC_INIT;
      answered_r <= 1'b0;
    end else if (ce) begin
      answered_r <= 1'b0;
      if (state_r == TBR_T_EVAL) begin
        tx_idx_r <= '0;
        tx_crc_r <= TBR_CRC_INIT;
      end else if (f_push) begin
        tx_idx_r <= tx_idx_r + 4'h1;
        if (tx_idx_r < TBR_RSP_CRC_POS) begin
          tx_crc_r <= tbr_crc_step(tx_crc_r, tx_byte);
        end
        if (tx_idx_r == TBR_RSP_LEN - 4'h1) begin
          answered_r <= 1'b1;
        end
      end
    end
  end

  tbr_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   ({tx_idx_r == TBR_RSP_LEN - 4'h1, tx_byte}),
    .in_valid  (state_r == TBR_T_TX),
    .in_ready  (f_ready),
    .out_data  (f_out),
    .out_valid (link.rs_valid),
    .out_ready (link.rs_ready)
  );

  assign link.rs_data = f_out[7:0];
  assign link.rs_last = f_out[8];
  assign halted       = halted_r;
  assign answered     = answered_r;
endmodule : tbr_tag

// ### tbr_reader.sv
// Reader end: sends request or wake-up, collects the answer, keeps the guard time
`timescale 1ns/1ps
module tbr_reader
  import tbr_pkg::*;
#(
  parameter int RESP_WAIT = 1024
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  tbr_link_if.reader       link,
  input  wire logic        start,
  input  wire logic        wakeup,
  input  wire logic [7:0]  afi,
  output logic             busy,
  output logic             atqb_valid,
  output logic             no_answer,
  output logic [31:0]      tag_pupi,
  output logic [3:0]       tag_fwi
);
  if (RESP_WAIT < 16 || RESP_WAIT > 65535) begin : g_chk
    $error("tbr_reader: RESP_WAIT out of range");
  end

  typedef enum logic [1:0] {
    TBR_R_IDLE  = 2'b00,
    TBR_R_SEND  = 2'b01,
    TBR_R_RECV  = 2'b10,
    TBR_R_GUARD = 2'b11
  } tbr_rstate_type;

  tbr_rstate_type state_r;
  logic [2:0]  sidx_r;
  logic [7:0]  afi_r;
  logic        wake_r;
  logic [15:0] scrc_r;
  logic [7:0]  sbyte;
  logic [3:0]  ridx_r;
  logic [15:0] rcrc_r;
  logic [7:0]  rbuf_r [TBR_RSP_LEN];
  logic [15:0] timer_r;
  logic        s_take;
  logic        r_take;
  logic        r_good;

  // Slot and extension bits are sent as zero, single slot
  always_comb begin
    case (sidx_r)
      3'h0:    sbyte = TBR_CMD_REQ; // R1
      3'h1:    sbyte = afi_r;
      3'h2:    sbyte = {4'h0, wake_r, 3'h0}; // R2 R3 R7
      3'h3:    sbyte = ~scrc_r[7:0]; // R1
      default: sbyte = ~scrc_r[15:8]; // R1
    endcase
  end

  assign link.rq_data  = sbyte;
  assign link.rq_valid = ce && (state_r == TBR_R_SEND);
  assign link.rq_last  = (sidx_r == TBR_REQ_LEN - 3'h1);
  assign link.rs_ready = ce && (state_r == TBR_R_RECV);
  assign s_take        = link.rq_valid && link.rq_ready;
  assign r_take        = link.rs_valid && link.rs_ready;
  assign busy          = (state_r != TBR_R_IDLE);

  assign r_good = (ridx_r == TBR_RSP_LEN - 4'h1) && (rbuf_r[0] == TBR_RSP_ATQB)
               && (~rcrc_r == {link.rs_data, rbuf_r[TBR_RSP_CRC_POS]});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= TBR_R_IDLE;
      timer_r <= '0;
    end else if (ce) begin
      case (state_r)
        TBR_R_IDLE: begin
          if (start) begin
            state_r <= TBR_R_SEND;
          end
        end
        TBR_R_SEND: begin
          if (s_take && link.rq_last) begin
            state_r <= TBR_R_RECV;
            timer_r <= 16'(RESP_WAIT);
          end
        end
        TBR_R_RECV: begin
          if (r_take && link.rs_last) begin
            state_r <= TBR_R_GUARD;
            timer_r <= 16'(TBR_GUARD_CYC); // R13
          end else if (timer_r == 16'h0000) begin
            state_r <= TBR_R_IDLE;
          end else begin
            timer_r <= timer_r - 16'h0001;
          end
        end
        default: begin
          if (timer_r == 16'h0001) begin
            state_r <= TBR_R_IDLE; // R13
          end
          timer_r <= timer_r - 16'h0001;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sidx_r <= '0;
      afi_r  <= '0;
      wake_r <= 1'b0;
      scrc_r <= TBR_CRC_INIT;
    end else if (ce) begin
      if (state_r == TBR_R_IDLE && start) begin
        sidx_r <= '0;
        afi_r  <= afi;
        wake_r <= wakeup;
        scrc_r <= TBR_CRC_INIT;
      end else if (s_take) begin
        sidx_r <= sidx_r + 3'h1;
        if (sidx_r < TBR_REQ_LEN - 3'h2) begin
          scrc_r <= tbr_crc_step(scrc_r, sbyte);
        end
      end
    end
  end

  // Index holds at the last byte, so longer answers pass the length check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ridx_r     <= '0;
      rcrc_r     <= TBR_CRC_INIT;
      atqb_valid <= 1'b0;
      no_answer  <= 1'b0;
      tag_pupi   <= '0;
      tag_fwi    <= '0;
      for (int i = 0; i < TBR_RSP_LEN; i++) begin
        rbuf_r[i] <= '0;
      end
    end else if (ce) begin
      atqb_valid <= 1'b0;
      no_answer  <= 1'b0;
      if (state_r == TBR_R_SEND) begin
        ridx_r <= '0;
        rcrc_r <= TBR_CRC_INIT;
      end else if (r_take) begin
        if (ridx_r != TBR_RSP_LEN - 4'h1) begin
          ridx_r <= ridx_r + 4'h1;
        end
        rbuf_r[ridx_r] <= link.rs_data;
        if (ridx_r < TBR_RSP_CRC_POS) begin
          rcrc_r <= tbr_crc_step(rcrc_r, link.rs_data);
        end
        if (link.rs_last) begin
          atqb_valid <= r_good;
          no_answer  <= !r_good;
          if (r_good) begin
            tag_pupi <= {rbuf_r[1], rbuf_r[2], rbuf_r[3], rbuf_r[4]};
            tag_fwi  <= rbuf_r[11][7:4];
          end
        end
      end else if (state_r == TBR_R_RECV && timer_r == 16'h0000) begin
        no_answer <= 1'b1;
      end
    end
  end
endmodule : tbr_reader

// ### tbr_link_checker.sv
// Assertions on the request and answer streams between reader and tag
`timescale 1ns/1ps
module tbr_link_checker
  import tbr_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] rq_data,
  input wire logic       rq_valid,
  input wire logic       rq_last,
  input wire logic       rq_ready,
  input wire logic [7:0] rs_data,
  input wire logic       rs_valid,
  input wire logic       rs_last,
  input wire logic       rs_ready
);
  logic [2:0] rq_idx_r;
  logic [3:0] rs_idx_r;
  int         gap_r;
  logic       rq_end;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  assign rq_end = rq_valid && rq_ready && rq_last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rq_idx_r <= 3'h0;
    end else if (rq_valid && rq_ready) begin
      rq_idx_r <= rq_last ? 3'h0 : rq_idx_r + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_idx_r <= 4'h0;
    end else if (rs_valid && rs_ready) begin
      rs_idx_r <= rs_last ? 4'h0 : rs_idx_r + 4'h1;
    end
  end

  // Starts saturated so the first request after reset is legal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= TBR_GUARD_CYC;
    end else if (rs_valid && rs_ready && rs_last) begin
      gap_r <= 0;
    end else if (gap_r < TBR_GUARD_CYC) begin
      gap_r <= gap_r + 1;
    end
  end

  a_req_code: assert property (rq_valid && rq_idx_r == 3'h0 |-> rq_data == TBR_CMD_REQ)
    else $error("request does not open with the request code");
  a_req_length: assert property (rq_valid && rq_last |-> rq_idx_r == 3'h4)
    else $error("request frame is not five bytes");
  a_param_spare: assert property (rq_valid && rq_idx_r == 3'h2
    |-> rq_data[7:5] == 3'h0 && rq_data[2:0] == 3'h0)
    else $error("parameter slot bits not zero");
  a_answer_code: assert property (rs_valid && rs_idx_r == 4'h0 |-> rs_data == TBR_RSP_ATQB)
    else $error("answer does not open with 50");
  a_app_zero: assert property (rs_valid && rs_idx_r inside {[5:8]} |-> rs_data == 8'h00)
    else $error("application data byte not zero");
  a_rate_byte: assert property (rs_valid && rs_idx_r == 4'h9 |-> rs_data == 8'h91)
    else $error("first protocol byte wrong");
  a_frame_byte: assert property (rs_valid && rs_idx_r == 4'ha |-> rs_data == 8'h81)
    else $error("second protocol byte wrong");
  a_proto_low: assert property (rs_valid && rs_idx_r == 4'hb |-> rs_data[3:0] == 4'h0)
    else $error("third protocol byte low nibble not zero");
  a_answer_len: assert property (rs_valid && rs_last |-> rs_idx_r == 4'hd)
    else $error("answer frame is not fourteen bytes");
  a_answer_prompt: assert property ($rose(rs_valid) && rs_idx_r == 4'h0
    |-> $past(rq_end, 2) || $past(rq_end, 3))
    else $error("answer not right after a request");
  a_guard_gap: assert property (rq_valid |-> gap_r == TBR_GUARD_CYC)
    else $error("request sent inside the turnaround guard");
endmodule : tbr_link_checker

// ### typeb_request_wakeup_responder_bench.sv
// Bench: reader and tag pair plus a second tag driven directly by the bench
`timescale 1ns/1ps
module typeb_request_wakeup_responder_bench;
  import tbr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        wakeup = 1'b0;
  logic        halt_req = 1'b0;
  logic [7:0]  afi = 8'h00;
  logic [7:0]  fc = 8'h00;
  logic [31:0] pupi = 32'h0;
  logic [3:0]  fwi = 4'h0;
  logic        busy, atqb_valid, no_answer, halted, answered, halted_b, answered_b;
  logic [31:0] tag_pupi;
  logic [3:0]  tag_fwi;
  logic [7:0]  rsp[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  bit          hm = 1'b0;
  logic        ce_b = 1'b1;
  logic        halt_b = 1'b0;
  int          frz = 0;
  int          ans_a = 0;
  int          ans_b = 0;

  tbr_link_if lk();
  tbr_link_if lk2();
  tbr_reader #(.RESP_WAIT(64)) u_tbr_reader (.clk, .rst, .ce(1'b1), .link(lk), .start, .wakeup,
    .afi, .busy, .atqb_valid, .no_answer, .tag_pupi, .tag_fwi);
  tbr_tag u_tbr_tag (.clk, .rst, .ce(1'b1), .link(lk), .family_code(fc), .pupi, .fwi, .halt_req,
    .halted, .answered);
  // Second tag faces the bench so frames the reader never sends can be tried
  tbr_tag u_tbr_tag_b (.clk, .rst, .ce(ce_b), .link(lk2), .family_code(fc), .pupi, .fwi,
    .halt_req(halt_b), .halted(halted_b), .answered(answered_b));
  tbr_link_checker u_tbr_link_checker (.clk, .rst, .rq_data(lk.rq_data), .rq_valid(lk.rq_valid),
    .rq_last(lk.rq_last), .rq_ready(lk.rq_ready), .rs_data(lk.rs_data), .rs_valid(lk.rs_valid),
    .rs_last(lk.rs_last), .rs_ready(lk.rs_ready));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (lk2.rs_valid && lk2.rs_ready) rsp.push_back(lk2.rs_data);
    if (answered) ans_a++;
    if (answered_b) ans_b++;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction : crc16

  task automatic halt_tag();
    @(negedge clk);
    halt_req = 1'b1;
    @(negedge clk);
    halt_req = 1'b0;
    hm = 1'b1;
  endtask : halt_tag

  task automatic trial(input logic [7:0] a, input logic w);
    bit ok;
    int n;
    int a0;
    ok = (a == 8'h00 || (a[3:0] == 4'h0 && a[7:4] == fc[7:4])
         || (a[7:4] == 4'h0 && a[3:0] == fc[3:0]) || a == fc) && (w || !hm);
    a0 = ans_a;
    @(negedge clk);
    afi = a;
    wakeup = w;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (!atqb_valid && !no_answer && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk({atqb_valid, no_answer}, ok ? 2'b10 : 2'b01);
    chk(ans_a - a0, 32'(ok));
    if (ok) begin
      chk(tag_pupi, pupi);
      chk(tag_fwi, fwi);
      hm = 1'b0;
    end
    chk(halted, hm);
    n = 0;
    while (busy && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n >= TBR_GUARD_CYC - 1 && n <= TBR_GUARD_CYC + 1), 32'(ok));
  endtask : trial

  task automatic send2(input logic [7:0] q[$]);
    // An edge passes first, so a following frame never re-raises valid in the same step
    @(negedge clk);
    foreach (q[i]) begin
      lk2.rq_data = q[i];
      lk2.rq_valid = 1'b1;
      lk2.rq_last = (i == q.size() - 1);
      while (!lk2.rq_ready) @(negedge clk);
      @(negedge clk);
    end
    lk2.rq_valid = 1'b0;
    lk2.rq_last = 1'b0;
    lk2.rq_data = ~lk2.rq_data;
  endtask : send2

  task automatic go2(input logic [7:0] c, input logic [7:0] p, input bit bad, input bit ext,
                     input int reps, input int want);
    logic [7:0]  q[$];
    logic [7:0]  e[$];
    logic [15:0] k;
    int          n;
    int          a0;
    q = '{c, 8'h00, p};
    k = crc16(q) ^ {15'h0, bad};
    q.push_back(k[7:0]);
    q.push_back(k[15:8]);
    if (ext) q.push_back(8'h3c);
    e = '{8'h50, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'h00, 8'h00, 8'h00, 8'h00,
          8'h91, 8'h81, {fwi, 4'h0}};
    k = crc16(e);
    e.push_back(k[7:0]);
    e.push_back(k[15:8]);
    rsp.delete();
    a0 = ans_b;
    // Stalling the drain lets a second answer pile up behind the first
    lk2.rs_ready = (reps == 1);
    repeat (reps) send2(q);
    // A frozen tag neither takes nor offers bytes, and resumes where it stopped
    if (frz > 0) begin
      repeat (4) @(negedge clk);
      ce_b = 1'b0;
      n = rsp.size();
      repeat (frz) @(negedge clk);
      chk({lk2.rq_ready, lk2.rs_valid}, 2'b00);
      chk(rsp.size(), n);
      ce_b = 1'b1;
    end
    repeat (60) @(negedge clk);
    if (reps > 1) chk(rsp.size(), 0);
    lk2.rs_ready = 1'b1;
    n = 0;
    while (rsp.size() < want * reps && n < 200) begin
      @(negedge clk);
      n++;
    end
    repeat (10) @(negedge clk);
    chk(rsp.size(), want * reps);
    chk(ans_b - a0, want * reps / 14);
    foreach (rsp[i]) chk(rsp[i], e[i % 14]);
  endtask : go2

  initial begin
    logic [7:0] a;
    int         r;
    lk2.rq_data = 8'h00;
    lk2.rq_valid = 1'b0;
    lk2.rq_last = 1'b0;
    lk2.rs_ready = 1'b1;
    void'($urandom(80594));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      fc = 8'($urandom);
      pupi = $urandom;
      fwi = 4'($urandom);
      if ($urandom % 3 == 0) halt_tag();
      r = $urandom % 5;
      a = r == 0 ? 8'h00 : r == 1 ? {fc[7:4], 4'h0} : r == 2 ? {4'h0, fc[3:0]} :
          r == 3 ? fc : 8'($urandom);
      trial(a, 1'($urandom));
    end
    halt_tag();
    trial(8'h00, 1'b0);
    trial(8'h00, 1'b1);
    frz = 5 + $urandom % 20;
    go2(TBR_CMD_REQ, {3'($urandom), 2'b00, 3'($urandom)}, 1'b0, 1'b0, 1, 14);
    frz = 0;
    go2(TBR_CMD_REQ, 8'h00, 1'b1, 1'b0, 1, 0);
    go2(TBR_CMD_REQ, 8'h08, 1'b0, 1'b1, 1, 0);
    go2(8'h06, 8'h00, 1'b0, 1'b0, 1, 0);
    go2(TBR_CMD_REQ, 8'h07, 1'b0, 1'b0, 2, 14);
    halt_b = 1'b1;
    @(negedge clk);
    halt_b = 1'b0;
    chk(halted_b, 1'b1);
    go2(TBR_CMD_REQ, 8'h00, 1'b0, 1'b0, 1, 0);
    chk(halted_b, 1'b1);
    go2(TBR_CMD_REQ, 8'h08, 1'b0, 1'b0, 1, 14);
    chk(halted_b, 1'b0);
    complete_run();
  end
endmodule : typeb_request_wakeup_responder_bench
